// >>> include/aci_pkg.sv
package aci_pkg;

	// ==========================================================================
	// Timing
	// ==========================================================================
	localparam int unsigned CLK_PERIOD_NS = 4;
	localparam int unsigned SYNC_STAGES = 2;
	// Integer-register scrub time after a soft init, in ns.
	localparam int unsigned INIT_SCRUB_NS = 32;
	localparam int unsigned INIT_SCRUB_CYC = (INIT_SCRUB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Self-test duration in ns.
	localparam int unsigned SELF_TEST_NS = 400;
	localparam int unsigned SELF_TEST_CYC = (SELF_TEST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CNT_W = 8;

	// ==========================================================================
	// Reset values
	// ==========================================================================
	localparam logic LIC_ENABLE_RST = 1'b1;
	localparam logic [31:0] RESET_VECTOR_DEF = 32'hFFFF_FFF0;

	// ==========================================================================
	// Types
	// ==========================================================================
	typedef struct packed {
		logic ignore_numeric_error_n;
		logic soft_init_n;
		logic local_irq_pin_zero;
		logic local_irq_pin_one;
	} aci_pins_t;

	typedef struct packed {
		logic maskable_irq_request;
		logic nonmaskable_irq;
		logic local_irq_zero;
		logic local_irq_one;
	} aci_irq_t;

	typedef enum logic [3:0] {
		ACI_RUN   = 4'b0001,
		ACI_INIT  = 4'b0010,
		ACI_BUILT_IN_SELF_TEST  = 4'b0100,
		ACI_HOLD  = 4'b1000
	} aci_state_t;

endpackage

// >>> src/aci_sync.sv
`timescale 1ns/1ns
module aci_sync
	import aci_pkg::*;
(
	input  wire logic      ref_clk,
	input  wire logic      nrst,
	input  wire aci_pins_t pins_async,
	output aci_pins_t      pins_sync
);
	import aci_pkg::*;

	// ==========================================================================
	// Two-stage synchroniser
	// ==========================================================================
	// The stages keep sampling through hard reset, so the soft init level is already
	// settled when reset lifts and the self-test choice sees the real pin, not an idle value.
	// Outputs that depend on the pins have their own reset, so no spurious event escapes.
	aci_pins_t stage_one;

	// The first stage feeds only the second stage; nrst is deliberately not used here.
	always_ff @(posedge ref_clk)
	begin
		stage_one <= pins_async;
		pins_sync <= stage_one;
	end
endmodule

// >>> src/aci_ctrl.sv
`timescale 1ns/1ns
// Notes on behaviour
// - Ignore-numeric-error asserted: pending FP error ignored, no exception raised.
// - Ignore-numeric-error deasserted: next noncontrol FP instruction faults if error pending.
// - With numeric-error-report enable set, the ignore input has no effect.
// - Soft init resets integer registers, keeps caches and FP registers.
// - After soft init, execution resumes at the configured reset vector.
// - Snoops are still serviced while soft init is held.
// - Soft init is asynchronous, shared by all agents, accepted without alignment.
// - Soft init active at hard reset release starts built-in self-test.
// - Controller disabled: pin zero is maskable request, pin one nonmaskable.
// - Local interrupt controller is enabled after reset.
module aci_ctrl
	import aci_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	input  wire aci_pins_t   pins,
	input  wire logic        numeric_error_report_enable,
	input  wire logic        fp_error_set,
	input  wire logic        fp_noncontrol_issue,
	input  wire logic        lic_config_we,
	input  wire logic        lic_config_enable,
	input  wire logic        snoop_req,
	input  wire logic [31:0] config_reset_vector,
	input  wire logic        config_vector_we,
	output logic             fp_exception,
	output logic             fp_error_pending,
	output aci_irq_t         irq_out,
	output logic             lic_enabled,
	output logic             int_regs_reset,
	output logic             fetch_start,
	output logic [31:0]      fetch_vector,
	output logic             self_test_active,
	output logic             exec_halted,
	output logic             snoop_ack
);
	import aci_pkg::*;

	// ==========================================================================
	// Synchronised pins
	// ==========================================================================
	aci_pins_t  pins_sync;
	aci_state_t state;
	aci_state_t next_state;
	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] next_count;
	logic [31:0] reset_vector;
	logic        hard_reset_seen;
	logic        boot_decided;

	aci_sync u_sync (
		.ref_clk    (ref_clk),
		.nrst       (nrst),
		.pins_async (pins),
		.pins_sync  (pins_sync)
	);

	// ==========================================================================
	// Numeric error handling
	// ==========================================================================
	// The ignore pin only counts when native error reporting is off.
	wire ignore_active = !pins_sync.ignore_numeric_error_n && !numeric_error_report_enable;
	wire raise_fp      = fp_noncontrol_issue && fp_error_pending && !ignore_active;
	wire running       = (state == ACI_RUN);

	// The pending flag is cleared when the exception is taken; a new error in that cycle wins.
	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
		begin
			fp_error_pending <= 1'b0;
			fp_exception     <= 1'b0;
		end
		else
		begin
			fp_exception     <= raise_fp && running;
			fp_error_pending <= fp_error_set || (fp_error_pending && !(raise_fp && running));
		end
	end

	// ==========================================================================
	// Local interrupt pin routing
	// ==========================================================================
	// Configuration is written by boot firmware through the controller's own space.
	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
			lic_enabled <= LIC_ENABLE_RST;
		else if (lic_config_we)
			lic_enabled <= lic_config_enable;
	end

	wire aci_irq_t next_irq = '{
		maskable_irq_request: !lic_enabled && pins_sync.local_irq_pin_zero,
		nonmaskable_irq:      !lic_enabled && pins_sync.local_irq_pin_one,
		local_irq_zero:       lic_enabled && pins_sync.local_irq_pin_zero,
		local_irq_one:        lic_enabled && pins_sync.local_irq_pin_one
	};

	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
			irq_out <= '0;
		else
			irq_out <= next_irq;
	end

	// ==========================================================================
	// Reset vector latch
	// ==========================================================================
	// Captured during power-on configuration; a soft init never changes it.
	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
			reset_vector <= RESET_VECTOR_DEF;
		else if (config_vector_we && !boot_decided)
			reset_vector <= config_reset_vector;
	end

	// ==========================================================================
	// Soft init and self-test sequencing
	// ==========================================================================
	// The soft init level is sampled on the second cycle after hard reset release.
	wire init_asserted = !pins_sync.soft_init_n;
	wire count_done    = (count == '0);

	always_comb
	begin
		next_state = state;
		next_count = (count_done) ? count : count - CNT_W'(1);
		unique case (state)
			ACI_HOLD:
			begin
				if (!hard_reset_seen)
					next_state = ACI_HOLD;
				else if (init_asserted)
				begin
					next_state = ACI_BUILT_IN_SELF_TEST;
					next_count = CNT_W'(SELF_TEST_CYC);
				end
				else
				begin
					next_state = ACI_INIT;
					next_count = CNT_W'(INIT_SCRUB_CYC);
				end
			end
			ACI_BUILT_IN_SELF_TEST:
			begin
				if (count_done && !init_asserted)
				begin
					next_state = ACI_INIT;
					next_count = CNT_W'(INIT_SCRUB_CYC);
				end
			end
			ACI_INIT:
			begin
				// Stay here while the pin is held; integer state keeps being cleared.
				if (init_asserted)
					next_count = CNT_W'(INIT_SCRUB_CYC);
				else if (count_done)
					next_state = ACI_RUN;
			end
			ACI_RUN:
			begin
				if (init_asserted)
				begin
					next_state = ACI_INIT;
					next_count = CNT_W'(INIT_SCRUB_CYC);
				end
			end
			default:
			begin
				next_state = ACI_HOLD;
			end
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
		begin
			state           <= ACI_HOLD;
			count           <= '0;
			hard_reset_seen <= 1'b0;
			boot_decided    <= 1'b0;
		end
		else
		begin
			state           <= next_state;
			count           <= next_count;
			hard_reset_seen <= 1'b1;
			boot_decided    <= boot_decided || (state != ACI_HOLD && hard_reset_seen);
		end
	end

	// ==========================================================================
	// Sequencer outputs
	// ==========================================================================
	// Caches and FP registers have no reset hook here, so they survive a soft init.
	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
		begin
			int_regs_reset   <= 1'b1;
			fetch_start      <= 1'b0;
			fetch_vector     <= RESET_VECTOR_DEF;
			self_test_active <= 1'b0;
			exec_halted      <= 1'b1;
		end
		else
		begin
			int_regs_reset   <= (next_state == ACI_INIT);
			fetch_start      <= (next_state == ACI_RUN) && (state != ACI_RUN);
			fetch_vector     <= reset_vector;
			self_test_active <= (next_state == ACI_BUILT_IN_SELF_TEST);
			exec_halted      <= (next_state != ACI_RUN);
		end
	end

	// ==========================================================================
	// Snoop service
	// ==========================================================================
	// Snoops are answered in every state so coherence holds across a soft init.
	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
			snoop_ack <= 1'b0;
		else
			snoop_ack <= snoop_req;
	end
endmodule

// >>> verif/aci_assertions.sv
`timescale 1ns/1ns
// ============================================================
// Port checker for the control-input block.
module aci_assertions
	import aci_pkg::*;
(
	input wire logic      ref_clk,
	input wire logic      nrst,
	input wire aci_pins_t pins,
	input wire logic      numeric_error_report_enable,
	input wire logic      fp_noncontrol_issue,
	input wire logic      lic_config_we,
	input wire logic      lic_config_enable,
	input wire logic      snoop_req,
	input wire logic      fp_exception,
	input wire logic      fp_error_pending,
	input wire aci_irq_t  irq_out,
	input wire logic      lic_enabled,
	input wire logic      int_regs_reset,
	input wire logic      fetch_start,
	input wire logic      exec_halted,
	input wire logic      snoop_ack
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);
	// Pin effects are timed from the pin, so the two synchroniser stages are counted in.
	property p_snoop; int_regs_reset && snoop_req |=> snoop_ack; endproperty
	a_snoop: assert property (p_snoop) else $error("snoop dropped in init");
	property p_irq; $rose(irq_out.maskable_irq_request) |-> $past(pins.local_irq_pin_zero, 3); endproperty
	a_irq: assert property (p_irq) else $error("maskable request without pin");
	property p_lic; lic_config_we |=> lic_enabled == $past(lic_config_enable); endproperty
	a_lic: assert property (p_lic) else $error("controller enable not written");
	property p_fp_exc; fp_exception |-> $past(fp_noncontrol_issue) && $past(fp_error_pending); endproperty
	a_fp_exc: assert property (p_fp_exc) else $error("exception without cause");
	property p_fp_ign;
		(!pins.ignore_numeric_error_n)[*3] ##0 (fp_noncontrol_issue && !numeric_error_report_enable) |=> !fp_exception;
	endproperty
	a_fp_ign: assert property (p_fp_ign) else $error("exception while ignored");
	property p_ne; numeric_error_report_enable && fp_noncontrol_issue && fp_error_pending && !exec_halted |=> fp_exception;
	endproperty
	a_ne: assert property (p_ne) else $error("report enable did not win");
	property p_init; !exec_halted && $fell(pins.soft_init_n) |-> ##3 int_regs_reset; endproperty
	a_init: assert property (p_init) else $error("soft init not taken");
	// The drop of the reset-time scrub level just after release is not a scrub end.
	property p_fetch; $past(nrst, 2) && $fell(int_regs_reset) |-> fetch_start && !exec_halted; endproperty
	a_fetch: assert property (p_fetch) else $error("no fetch after scrub");
	property p_scrub; $rose(pins.soft_init_n) && int_regs_reset |-> int_regs_reset[*8] ##[1:8] fetch_start; endproperty
	a_scrub: assert property (p_scrub) else $error("scrub length wrong");
	c_exc: cover property (fp_exception);
	c_fetch: cover property (fetch_start);
	c_nmi: cover property (irq_out.nonmaskable_irq);
endmodule
bind aci_ctrl aci_assertions u_chk (.ref_clk, .nrst, .pins, .numeric_error_report_enable, .fp_noncontrol_issue,
	.lic_config_we, .lic_config_enable, .snoop_req, .fp_exception, .fp_error_pending, .irq_out, .lic_enabled,
	.int_regs_reset, .fetch_start, .exec_halted, .snoop_ack);

// >>> verif/aci_core_model.sv
`timescale 1ns/1ns
// ============================================================
// Core logic that drives the control pins.
module aci_core_model
	import aci_pkg::*;
(
	input wire logic      ref_clk,
	input wire aci_pins_t want,
	output aci_pins_t     pins
);
	// Lines move just after an edge, unrelated to any bus phase, so the block must synchronise them.
	initial pins = '1;
	always @(posedge ref_clk) pins <= #1 want;
endmodule

// >>> verif/tb_cpu_async_control_inputs.sv
`timescale 1ns/1ns
// ============================================================
// Bench for the asynchronous control inputs.
module tb_cpu_async_control_inputs;
	import aci_pkg::*;
	logic        ref_clk, nrst, numeric_error_report_enable, fp_error_set, fp_noncontrol_issue;
	logic        lic_config_we, lic_config_enable, snoop_req, config_vector_we, fp_exception;
	logic        fp_error_pending, lic_enabled, int_regs_reset, fetch_start, self_test_active;
	logic        exec_halted, snoop_ack;
	logic [31:0] config_reset_vector, fetch_vector, r;
	logic [31:0] vq[$];
	aci_pins_t   want, pins;
	aci_irq_t    irq_out;
	int          fails, num_checks, pend, n;
	aci_core_model u_core (.ref_clk, .want, .pins);
	aci_ctrl u_dut (.ref_clk, .nrst, .pins, .numeric_error_report_enable, .fp_error_set, .fp_noncontrol_issue,
		.lic_config_we, .lic_config_enable, .snoop_req, .config_reset_vector, .config_vector_we, .fp_exception,
		.fp_error_pending, .irq_out, .lic_enabled, .int_regs_reset, .fetch_start, .fetch_vector, .self_test_active,
		.exec_halted, .snoop_ack);
	initial
	begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	// Inputs always move one nanosecond after the edge.
	task automatic cyc(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("ERROR %0t got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish();
		if (fails == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Bounded wait for the fetch pulse; n keeps the cycles it took.
	task automatic wait_fetch();
		n = 0;
		while (fetch_start !== 1'b1 && n < 400)
		begin
			cyc(1);
			n++;
		end
		if (n >= 400)
		begin
			fails++;
			tally_and_finish();
		end
	endtask
	initial
	begin
		fails = 0;
		num_checks = 0;
		r = $urandom(32'h0A812C1C);
		{nrst, numeric_error_report_enable, fp_error_set, fp_noncontrol_issue} = 4'h0;
		{lic_config_we, lic_config_enable, snoop_req} = 3'h0;
		config_reset_vector = $urandom();
		vq.push_back(config_reset_vector);
		config_vector_we = 1'b1;
		want = 4'hB;
		cyc(4);
		chk(lic_enabled, 1'b1);
		chk(fetch_vector, RESET_VECTOR_DEF);
		nrst = 1'b1;
		cyc(1);
		config_vector_we = 1'b0;
		cyc(2);
		chk(self_test_active, 1'b1);
		want.soft_init_n = 1'b1;
		wait_fetch();
		chk(n > SELF_TEST_CYC - 2, 1'b1);
		chk(fetch_vector, vq[0]);
		// Every mix of ignore pin and report enable, with an error left pending each time.
		pend = 0;
		for (int c = 0; c < 4; c++)
		begin
			want.ignore_numeric_error_n = c[0];
			numeric_error_report_enable = c[1];
			fp_error_set = 1'b1;
			cyc(1);
			fp_error_set = 1'b0;
			pend = 1;
			cyc(4);
			fp_noncontrol_issue = 1'b1;
			cyc(1);
			fp_noncontrol_issue = 1'b0;
			chk(fp_exception, c != 0);
			if (c != 0)
				pend = 0;
			chk(fp_error_pending, pend);
		end
		// Pin roles follow the controller enable.
		for (int c = 0; c < 4; c++)
		begin
			lic_config_we = 1'b1;
			lic_config_enable = c[1];
			r = $urandom();
			want.local_irq_pin_zero = r[0];
			want.local_irq_pin_one = r[1];
			cyc(1);
			lic_config_we = 1'b0;
			cyc(5);
			chk(lic_enabled, c[1]);
			chk(irq_out, c[1] ? {2'b00, r[0], r[1]} : {r[0], r[1], 2'b00});
		end
		want.soft_init_n = 1'b0;
		snoop_req = 1'b1;
		cyc(5);
		chk(int_regs_reset, 1'b1);
		chk(exec_halted, 1'b1);
		chk(snoop_ack, 1'b1);
		want.soft_init_n = 1'b1;
		snoop_req = 1'b0;
		wait_fetch();
		chk(fetch_vector, vq.pop_front());
		chk(exec_halted, 1'b0);
		tally_and_finish();
	end
endmodule
